// ### common/mcpt_regs.vh
// register map, field positions and reset values of the multi channel pwm timer
`ifndef MCPT_REGS_VH
`define MCPT_REGS_VH

// register offsets (byte addresses, one word each)
`define MCPT_IR_OFF   8'h00
`define MCPT_TCR_OFF  8'h04
`define MCPT_TC_OFF   8'h08
`define MCPT_PR_OFF   8'h0c
`define MCPT_PC_OFF   8'h10
`define MCPT_MCR_OFF  8'h14
// first and last staged match word
`define MCPT_MATCH_LO_OFF 8'h18
`define MCPT_MATCH_HI_OFF 8'h30
`define MCPT_LER_OFF  8'h34
`define MCPT_PCR_OFF  8'h38
`define MCPT_IMR_OFF  8'h3c

// control register fields
`define MCPT_TCR_EN   0
`define MCPT_TCR_RST  1
`define MCPT_TCR_PWM  3

// match control: three bits per match register
`define MCPT_MCR_INT  0
`define MCPT_MCR_RST  1
`define MCPT_MCR_STP  2

// output control: double-edge selects at 6:2, enables at 14:9
`define MCPT_PCR_SEL_LO 2
`define MCPT_PCR_EN_LO  9

// reset values
`define MCPT_TCR_RESET 4'h0
`define MCPT_MR_RESET  32'h00000000
`define MCPT_PR_RESET  32'h00000000

`endif

// ### design/mcpt_prescale.v
// prescaler that turns the clock into counter advance pulses
`timescale 1ns/1ps
module mcpt_prescale #(
	parameter W = 32
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire         run,
	input  wire         clear,
	input  wire [W-1:0] limit,
	output wire         tick,
	output wire [W-1:0] count
);
	reg [W-1:0] pc_q;

	// one tick every limit+1 clocks while running
	assign tick  = run & ~clear & (pc_q == limit);
	assign count = pc_q;

	// prescale counter, cleared on wrap or hold
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_q <= {W{1'b0}};
		end else if (clear) begin
			pc_q <= {W{1'b0}};
		end else if (run) begin
			if (pc_q == limit) begin
				pc_q <= {W{1'b0}};
			end else begin
				pc_q <= pc_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // mcpt_prescale

// ### design/mcpt_top.v
// multi channel pwm timer: counter, seven match registers, six pulse outputs
//
// What this block does
// - a 32-bit counter advances on clock cycles divided by a 32-bit prescaler
// - seven match registers each compare with the counter and raise a match event
// - the cycle match register sets the period and, in pulse mode, resets the counter on match
// - single-edge outputs rise on each cycle match unless held constantly low
// - a single-edge output places its other edge with one more match register
// - double-edge outputs use a rise and a fall register; order gives pulse polarity
// - double-edge edges may sit at any count within the period
// - six single-edge, three double-edge, or any mix fitting the match registers
// - each match may continue, stop or reset the counter, with optional interrupt
// - period and width take any count; all outputs share one repetition rate
// - software releases new match values; in pulse mode they apply only in step with outputs, as a plain timer at once
// - with pulse mode off the block is a plain timer, matches still active
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "mcpt_regs.vh"
module mcpt_top #(
	parameter CW = 32,
	parameter NM = 7
) (
	input  wire          clk,
	input  wire          sys_rst,
	input  wire [7:0]    reg_addr,
	input  wire [31:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [31:0]   reg_rdata,
	output reg           irq,
	output reg  [6:1]    pwm_out
);
	// pick one kind of match action out of the match control word
	function [NM-1:0] mcr_pick;
		input [3*NM-1:0] mcr;
		input integer    kind;
		integer          k;
		begin
			mcr_pick = {NM{1'b0}};
			for (k = 0; k < NM; k = k + 1) begin
				mcr_pick[k] = mcr[3*k+kind];
			end
		end
	endfunction

	// true when the address falls on a match register word
	function is_mr;
		input [7:0] a;
		begin
			is_mr = (a >= `MCPT_MATCH_LO_OFF) && (a <= `MCPT_MATCH_HI_OFF) && (a[1:0] == 2'b00);
		end
	endfunction

	// index of the match register word at an address
	function [2:0] mr_idx;
		input [7:0] a;
		reg   [7:0] d;
		begin
			d      = a - `MCPT_MATCH_LO_OFF;
			mr_idx = d[4:2];
		end
	endfunction

	// software visible state
	reg [3:0]      tcr_q;
	reg [CW-1:0]   tc_q;
	reg [CW-1:0]   pr_q;
	reg [3*NM-1:0] mcr_q;
	reg [NM-1:0]   ler_q;
	reg [14:0]     pcr_q;
	reg [NM-1:0]   ir_q;
	reg [NM-1:0]   imr_q;
	reg [CW-1:0]   mr_sh_q  [0:NM-1];
	reg [CW-1:0]   mr_act_q [0:NM-1];

	// combinational results
	reg [NM-1:0]   hit;
	reg            do_rst;
	reg            do_stop;
	reg            apply;
	reg [NM-1:0]   ir_d;
	reg [NM-1:0]   ir_clr;
	reg [6:1]      pwm_d;
	reg            set_e;
	reg            clr_e;
	reg [31:0]     rd_d;
	reg            irq_d;

	// next values of the registers
	reg [CW-1:0]   tc_d;
	reg [3:0]      tcr_d;
	reg [NM-1:0]   ler_d;
	wire           tick;
	wire [CW-1:0]  pc_val;
	wire           run;
	wire           hold;
	wire           pwm_en;
	wire           wr_tcr;

	// decoded strobes and match actions
	wire           wr_tc;
	wire           wr_ler;
	wire           wr_mr;
	wire           wr_ir;
	wire           rd_ir;
	wire [NM-1:0]  int_en;
	wire [NM-1:0]  rst_en;
	wire [NM-1:0]  stp_en;
	integer        i;
	integer        n;
	integer        j;

	assign run    = tcr_q[`MCPT_TCR_EN];
	assign hold   = tcr_q[`MCPT_TCR_RST];
	assign pwm_en = tcr_q[`MCPT_TCR_PWM];
	assign wr_tcr = reg_wr && (reg_addr == `MCPT_TCR_OFF);

	// register strobes decoded once
	assign wr_tc  = reg_wr && (reg_addr == `MCPT_TC_OFF);
	assign wr_ler = reg_wr && (reg_addr == `MCPT_LER_OFF);
	assign wr_mr  = reg_wr && is_mr(reg_addr);
	assign wr_ir  = reg_wr && (reg_addr == `MCPT_IR_OFF);
	assign rd_ir  = reg_rd && (reg_addr == `MCPT_IR_OFF);

	// match actions split out of the match control word
	assign int_en = mcr_pick(mcr_q, `MCPT_MCR_INT);
	assign rst_en = mcr_pick(mcr_q, `MCPT_MCR_RST);
	assign stp_en = mcr_pick(mcr_q, `MCPT_MCR_STP);

	// prescaler feeding the counter
	// hold clears it too, so a restart begins on a full step
	mcpt_prescale #(
		.W(CW)
	) u_pre (
		.clk    (clk),
		.sys_rst(sys_rst),
		.run    (run),
		.clear  (hold),
		.limit  (pr_q),
		.tick   (tick),
		.count  (pc_val)
	);

	// match compare, one event per counter value
	always @* begin
		hit = {NM{1'b0}};
		// tick gates the compare so a held count gives no repeat event
		for (i = 0; i < NM; i = i + 1) begin
			hit[i] = tick & (tc_q == mr_act_q[i]);
		end
		// cycle match always restarts the period in pulse mode
		do_rst  = |(hit & rst_en) | (hit[0] & pwm_en);
		do_stop = |(hit & stp_en);
		// released values go live at period start, or at once as a plain timer
		apply   = pwm_en ? hit[0] : 1'b1;
	end

	// interrupt flags: read or write-one clears, a new match wins
	always @* begin
		ir_clr = {NM{1'b0}};
		if (rd_ir) begin
			ir_clr = ir_q;
		end else if (wr_ir) begin
			ir_clr = reg_wdata[NM-1:0];
		end
		// set term last so a match in the clearing cycle is kept
		ir_d  = (ir_q & ~ir_clr) | (hit & int_en);
		irq_d = |(ir_d & imr_q);
	end

	// pulse outputs: single edge rises on cycle match, double edge on its own
	// clear wins, so an edge match equal to the set match holds the output low
	always @* begin
		pwm_d = pwm_out;
		for (n = 1; n <= 6; n = n + 1) begin
			if ((n >= 2) && pcr_q[`MCPT_PCR_SEL_LO+n-2]) begin
				set_e = hit[n-1];
			end else begin
				set_e = hit[0];
			end
			clr_e = hit[n];
			if (!pwm_en || !pcr_q[`MCPT_PCR_EN_LO+n-1]) begin
				pwm_d[n] = 1'b0;
			end else if (clr_e) begin
				pwm_d[n] = 1'b0;
			end else if (set_e) begin
				pwm_d[n] = 1'b1;
			end
		end
		set_e = 1'b0;
		clr_e = 1'b0;
	end

	// read data mux
	// unmapped words and reserved bits read as zero, save output control bits 1:0 and 8:7, which read back as written
	always @* begin
		rd_d = 32'h00000000;
		if (reg_addr == `MCPT_IR_OFF) begin
			rd_d[NM-1:0] = ir_q;
		end else if (reg_addr == `MCPT_TCR_OFF) begin
			rd_d[3:0] = tcr_q;
		end else if (reg_addr == `MCPT_TC_OFF) begin
			rd_d = tc_q;
		end else if (reg_addr == `MCPT_PR_OFF) begin
			rd_d = pr_q;
		end else if (reg_addr == `MCPT_PC_OFF) begin
			rd_d = pc_val;
		end else if (reg_addr == `MCPT_MCR_OFF) begin
			rd_d[3*NM-1:0] = mcr_q;
		end else if (is_mr(reg_addr)) begin
			rd_d = mr_sh_q[mr_idx(reg_addr)];
		end else if (reg_addr == `MCPT_LER_OFF) begin
			rd_d[NM-1:0] = ler_q;
		end else if (reg_addr == `MCPT_PCR_OFF) begin
			rd_d[14:0] = pcr_q;
		end else if (reg_addr == `MCPT_IMR_OFF) begin
			rd_d[NM-1:0] = imr_q;
		end
	end

	// bus answer registered one cycle after the read strobe
	// zero outside the answer cycle so stale data never lingers
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rd_d;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// control registers written by software
	// writes to read-only or unmapped words are dropped
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pr_q  <= `MCPT_PR_RESET;
			mcr_q <= {(3*NM){1'b0}};
			pcr_q <= 15'h0000;
			imr_q <= {NM{1'b0}};
		end else if (reg_wr) begin
			if (reg_addr == `MCPT_PR_OFF) begin
				pr_q <= reg_wdata;
			end else if (reg_addr == `MCPT_MCR_OFF) begin
				mcr_q <= reg_wdata[3*NM-1:0];
			end else if (reg_addr == `MCPT_PCR_OFF) begin
				pcr_q <= reg_wdata[14:0];
			end else if (reg_addr == `MCPT_IMR_OFF) begin
				imr_q <= reg_wdata[NM-1:0];
			end
		end
	end

	// timer control next value: a stop match drops the enable after any write
	always @* begin
		tcr_d = tcr_q;
		if (wr_tcr) begin
			tcr_d = {reg_wdata[3], 1'b0, reg_wdata[1:0]};
		end
		if (do_stop) begin
			tcr_d[`MCPT_TCR_EN] = 1'b0;
		end
	end

	// timer control register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tcr_q <= `MCPT_TCR_RESET;
		end else begin
			tcr_q <= tcr_d;
		end
	end

	// counter next value: software write, hold, match reset, stop or advance
	// a stop match freezes the count on the value that matched unless do_rst clears it on the same tick
	always @* begin
		tc_d = tc_q;
		if (wr_tc) begin
			tc_d = reg_wdata;
		end else if (hold) begin
			tc_d = {CW{1'b0}};
		end else if (tick) begin
			if (do_rst) begin
				tc_d = {CW{1'b0}};
			end else if (!do_stop) begin
				tc_d = tc_q + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

	// main counter register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tc_q <= {CW{1'b0}};
		end else begin
			tc_q <= tc_d;
		end
	end

	// release bits: a release written with an apply stays pending
	always @* begin
		ler_d = apply ? {NM{1'b0}} : ler_q;
		if (wr_ler) begin
			ler_d = ler_d | reg_wdata[NM-1:0];
		end
	end

	// staged match values, live copies and release bits
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ler_q <= {NM{1'b0}};
			for (j = 0; j < NM; j = j + 1) begin
				mr_sh_q[j]  <= `MCPT_MR_RESET;
				mr_act_q[j] <= `MCPT_MR_RESET;
			end
		end else begin
			// live copies only move on apply, so a period keeps its settings
			if (apply) begin
				for (j = 0; j < NM; j = j + 1) begin
					if (ler_q[j]) begin
						mr_act_q[j] <= mr_sh_q[j];
					end
				end
			end
			ler_q <= ler_d;
			if (wr_mr) begin
				mr_sh_q[mr_idx(reg_addr)] <= reg_wdata;
			end
		end
	end

	// flags, interrupt line and outputs, all from flip-flops
	// registered so the pins never glitch on a compare
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ir_q    <= {NM{1'b0}};
			irq     <= 1'b0;
			pwm_out <= 6'h00;
		end else begin
			ir_q    <= ir_d;
			irq     <= irq_d;
			pwm_out <= pwm_d;
		end
	end
endmodule // mcpt_top

// ### testbench/mcpt_checker.sv
// port checker for the pwm timer
`timescale 1ns/1ps
module mcpt_checker (
	input logic        clk,
	input logic        sys_rst,
	input logic [7:0]  reg_addr,
	input logic [31:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [31:0] reg_rdata,
	input logic        irq,
	input logic [6:1]  pwm_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [6:0] mask_q;
	logic [5:0] en_q;
	logic       pm_q;
	// shadow of mask, output enables and pulse mode
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_q <= 7'h0;
			en_q   <= 6'h0;
			pm_q   <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h3c) mask_q <= reg_wdata[6:0];
			if (reg_addr == 8'h38) en_q <= reg_wdata[14:9];
			if (reg_addr == 8'h04) pm_q <= reg_wdata[3];
		end
	end
	sequence s_mask_wr;
		reg_wr && reg_addr == 8'h3c;
	endsequence
	sequence s_mask_rd;
		reg_rd && reg_addr == 8'h3c;
	endsequence
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_RSVD: assert property (reg_rd && reg_addr == 8'h04 |=> !reg_rdata[2])
		else $error("reserved control bit set");
	AST_MASK_BACK: assert property (s_mask_wr ##2 s_mask_rd |=>
		reg_rdata == {25'h0, $past(reg_wdata[6:0], 3)}) else $error("mask readback");
	AST_MODE_OFF: assert property (|pwm_out |-> $past(pm_q) || $past(pm_q, 2))
		else $error("output high with pulse mode off");
	AST_EN_OFF: assert property ((pwm_out & ~($past(en_q) | $past(en_q, 2))) == 6'h0)
		else $error("disabled output high");
	AST_IRQ_MASK: assert property (irq |-> $past(mask_q) != 7'h0 || $past(mask_q, 2) != 7'h0)
		else $error("irq with all masked");
	AST_IRQ_HOLD: assert property (irq && !reg_rd && !reg_wr && !$past(reg_rd)
		&& !$past(reg_wr) |=> irq) else $error("irq dropped untouched");
endmodule // mcpt_checker
bind mcpt_top mcpt_checker chk_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.irq(irq), .pwm_out(pwm_out));

// ### testbench/mcpt_load.sv
// load model that times one pulse output
`timescale 1ns/1ps
module mcpt_load (
	input  wire        clk,
	input  wire [6:1]  pwm_out,
	input  wire [2:0]  sel,
	output reg  [15:0] hi_q,
	output reg  [15:0] per_q
);
	reg        line_q;
	reg [15:0] cnt_q;
	// high time and period in clocks
	always @(posedge clk) begin
		line_q <= pwm_out[sel];
		cnt_q  <= cnt_q + 16'h1;
		if (pwm_out[sel] && !line_q) begin
			per_q <= cnt_q;
			cnt_q <= 16'h1;
		end
		if (!pwm_out[sel] && line_q)
			hi_q <= cnt_q;
	end
endmodule // mcpt_load

// ### testbench/tb.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ps
module tb;
	reg         clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg  [7:0]  reg_addr = 8'h0;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [2:0]  sel = 3'h1;
	wire [31:0] reg_rdata;
	wire        irq;
	wire [6:1]  pwm_out;
	wire [15:0] hi;
	wire [15:0] per;
	integer     miscompares = 0;
	integer     checks = 0;
	// 40 mhz clock
	always #12.5 clk = ~clk;
	mcpt_top #(.CW(32), .NM(7)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .pwm_out(pwm_out));
	mcpt_load ld (.clk(clk), .pwm_out(pwm_out), .sel(sel), .hi_q(hi), .per_q(per));
	task chk(input [31:0] g, input [31:0] e);
		checks = checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata & m, e);
	endtask
	task meas(input [31:0] h, input [31:0] p);
		repeat (40) @(negedge clk);
		chk(hi, h);
		chk(per, p);
	endtask
	task end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#200000;
		miscompares = miscompares + 1;
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h04, ~32'h0, 32'h0);
		rd(8'h18, ~32'h0, 32'h0);
		rd(8'h40, ~32'h0, 32'h0);
		wr(8'h0c, 32'h1);
		wr(8'h18, 32'h4);
		wr(8'h1c, 32'h2);
		wr(8'h34, 32'h3);
		wr(8'h14, 32'h8);
		wr(8'h3c, 32'h2);
		rd(8'h3c, ~32'h0, 32'h2);
		wr(8'h38, 32'h200);
		wr(8'h04, 32'h9);
		// high (match1+1) ticks, period (match0+1) ticks, two clocks a tick
		meas(32'h6, 32'ha);
		chk(irq, 32'h1);
		rd(8'h00, 32'h2, 32'h2);
		wr(8'h3c, 32'h0);
		repeat (3) @(negedge clk);
		chk(irq, 32'h0);
		sel <= 3'h2;
		wr(8'h38, 32'h404);
		wr(8'h20, 32'h3);
		wr(8'h34, 32'h4);
		meas(32'h2, 32'ha);
		wr(8'h1c, 32'h3);
		wr(8'h20, 32'h1);
		wr(8'h34, 32'h6);
		meas(32'h6, 32'ha);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h24, 32'h7);
		wr(8'h34, 32'h8);
		wr(8'h14, 32'h800);
		wr(8'h04, 32'h1);
		repeat (40) @(negedge clk);
		chk(pwm_out, 32'h0);
		// a stop match leaves the count on the matching value
		rd(8'h08, ~32'h0, 32'h7);
		rd(8'h04, ~32'h0, 32'h0);
		end_of_test;
	end
endmodule // tb
